//--- design/cfgpc_top.sv
// Configuration pin controller: restart, serial load, chain, init and overrides
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module cfgpc_top import cfgpc_pkg::*; #(
	parameter int IO_W = 8,
	parameter int INIT_CNT = INIT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic config_restart_n,
	input wire logic [1:0] config_mode_select,
	input wire logic chain_enable_in_n,
	output logic chain_enable_out_n,
	input wire logic config_bit_clock_in,
	output logic config_bit_clock_out,
	output logic config_bit_clock_oe,
	input wire logic config_serial_in,
	output logic flash_serial_out,
	output logic flash_serial_oe,
	output logic flash_select_n,
	output logic flash_select_oe,
	input wire logic load_complete_in,
	output logic load_complete_out,
	output logic load_complete_oe,
	input wire logic load_status_n_in,
	output logic load_status_n_out,
	output logic load_status_n_oe,
	output logic init_done_out,
	output logic init_done_oe,
	input wire logic init_user_clock,
	input wire logic global_clear_n,
	input wire logic global_output_enable,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tck,
	output logic tdo,
	input wire logic [IO_W-1:0] user_oe_req,
	output logic [IO_W-1:0] user_io_oe,
	output logic user_reg_clear_n,
	output logic user_mode,
	output logic [31:0] cfg_word,
	output logic cfg_word_valid
);
	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	localparam int NS = 13;
	logic [NS-1:0] sync_s;
	cfgpc_sync #(.W(NS)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({~config_restart_n, config_mode_select, chain_enable_in_n,
			config_bit_clock_in, config_serial_in, load_complete_in, load_status_n_in,
			init_user_clock, global_clear_n, global_output_enable, tms, tdi}),
		.sync_out(sync_s)
	);
	logic tck_s;
	cfgpc_sync #(.W(1)) u_sync_tck (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(tck),
		.sync_out(tck_s)
	);
	// Restart synced inverted: reset value matches the idle-high pin, so no false start after reset
	wire restart_s = !sync_s[12];
	wire [1:0] msel_s = sync_s[11:10];
	wire ce_n_s = sync_s[9];
	wire config_bit_clock_s = sync_s[8];
	wire data_s = sync_s[7];
	wire done_pin_s = sync_s[6];
	wire status_pin_s = sync_s[5];
	wire uclk_s = sync_s[4];
	wire gclr_s = sync_s[3];
	wire goe_s = sync_s[2];
	wire tms_s = sync_s[1];
	wire tdi_s = sync_s[0];

	// Edge detection on synchronised levels
	logic restart_prev_q;
	logic config_bit_clock_prev_q;
	logic uclk_prev_q;
	logic tck_prev_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			restart_prev_q <= 1'b1;
			config_bit_clock_prev_q <= 1'b0;
			uclk_prev_q <= 1'b0;
			tck_prev_q <= 1'b0;
		end else begin
			restart_prev_q <= restart_s;
			config_bit_clock_prev_q <= config_bit_clock_s;
			uclk_prev_q <= uclk_s;
			tck_prev_q <= tck_s;
		end
	end
	wire restart_rise = restart_s && !restart_prev_q;
	wire config_bit_clock_rise = config_bit_clock_s && !config_bit_clock_prev_q;
	wire uclk_rise = uclk_s && !uclk_prev_q;
	wire tck_rise = tck_s && !tck_prev_q;
	wire tck_fall = !tck_s && tck_prev_q;

	// ***************************************************************
	// Register file
	// ***************************************************************
	cfgpc_state_t state_q;
	cfgpc_state_t state_d;
	logic mode_as_q;
	logic [31:0] bit_cnt_q;
	logic [31:0] ctrl_q;
	logic [31:0] len_q;
	wire [31:0] stat_w = {24'h00_0000, status_pin_s, done_pin_s, mode_as_q, user_mode, 1'b0, state_q};
	cfgpc_axil u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.stat_in(stat_w),
		.count_in(bit_cnt_q),
		.ctrl_q(ctrl_q),
		.len_q(len_q)
	);
	wire clr_en = ctrl_q[CTRL_CLR_EN];
	wire oe_en = ctrl_q[CTRL_OE_EN];
	wire done_en = ctrl_q[CTRL_DONE_EN];
	wire uclk_en = ctrl_q[CTRL_UCLK_EN];

	// ***************************************************************
	// Active serial clock divider and header shifter
	// ***************************************************************
	logic [7:0] div_q;
	logic config_bit_clock_q;
	logic [5:0] hdr_cnt_q;
	logic [31:0] hdr_sr_q;
	wire as_load = state_q == ST_LOAD && mode_as_q;
	wire div_wrap = div_q == 8'(AS_HALF_CYC - 1);
	wire as_rise = as_load && div_wrap && !config_bit_clock_q;
	wire as_fall = as_load && div_wrap && config_bit_clock_q;
	wire hdr_done = hdr_cnt_q == 6'(HDR_BITS);
	always_ff @(posedge aclk) begin
		if (!aresetn || !as_load) begin
			div_q <= 8'h00;
			config_bit_clock_q <= 1'b0;
		end else begin
			div_q <= div_wrap ? 8'h00 : div_q + 8'h01;
			config_bit_clock_q <= div_wrap ? !config_bit_clock_q : config_bit_clock_q;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !as_load) begin
			hdr_cnt_q <= 6'h00;
			hdr_sr_q <= AS_HEADER;
		end else begin
			if (as_rise && !hdr_done) begin
				hdr_cnt_q <= hdr_cnt_q + 6'h01;
			end
			if (as_fall && hdr_cnt_q != 6'h00 && !hdr_done) begin
				hdr_sr_q <= {hdr_sr_q[30:0], 1'b0};
			end
		end
	end

	// ***************************************************************
	// Serial data capture
	// ***************************************************************
	wire bit_take = state_q == ST_LOAD && (mode_as_q ? (as_rise && hdr_done) : config_bit_clock_rise);
	wire load_end = bit_cnt_q == len_q && len_q != 32'h0000_0000;
	logic [31:0] shift_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || state_q == ST_CLEAR) begin
			bit_cnt_q <= 32'h0000_0000;
			shift_q <= 32'h0000_0000;
			cfg_word <= 32'h0000_0000;
			cfg_word_valid <= 1'b0;
		end else begin
			cfg_word_valid <= 1'b0;
			if (bit_take) begin
				bit_cnt_q <= bit_cnt_q + 32'h0000_0001;
				shift_q <= {shift_q[30:0], data_s};
				if (bit_cnt_q[4:0] == 5'h1f) begin
					cfg_word <= {shift_q[30:0], data_s};
					cfg_word_valid <= 1'b1;
				end
			end
		end
	end

	// ***************************************************************
	// Initialization pacing
	// ***************************************************************
	logic [15:0] init_cnt_q;
	wire init_tick = uclk_en ? uclk_rise : 1'b1;
	wire init_end = init_cnt_q == 16'(INIT_CNT);
	always_ff @(posedge aclk) begin
		if (!aresetn || state_q != ST_INIT) begin
			init_cnt_q <= 16'h0000;
		end else if (init_tick && !init_end) begin
			init_cnt_q <= init_cnt_q + 16'h0001;
		end
	end

	// ***************************************************************
	// Configuration sequencer
	// ***************************************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_CLEAR: begin
				if (restart_rise) begin
					state_d = ce_n_s ? ST_WAIT : ST_LOAD;
				end
			end
			ST_WAIT: begin
				if (!ce_n_s) begin
					state_d = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (ce_n_s || !status_pin_s) begin
					state_d = ST_WAIT;
				end else if (load_end && done_pin_s) begin
					state_d = ST_INIT;
				end
			end
			ST_INIT: begin
				if (init_end) begin
					state_d = ST_USER;
				end
			end
			ST_USER: begin
				state_d = ST_USER;
			end
			default: begin
				state_d = ST_CLEAR;
			end
		endcase
		if (!restart_s) begin
			state_d = ST_CLEAR;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_CLEAR;
			mode_as_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (restart_rise) begin
				mode_as_q <= msel_s == MODE_AS;
			end
		end
	end

	// ***************************************************************
	// Pin drivers
	// ***************************************************************
	logic byp_q;
	logic tdo_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			byp_q <= 1'b0;
			tdo_q <= 1'b0;
			user_reg_clear_n <= 1'b0;
		end else begin
			if (tck_rise && !tms_s) begin
				byp_q <= tdi_s;
			end
			if (tck_fall) begin
				tdo_q <= byp_q;
			end
			user_reg_clear_n <= state_q == ST_USER && !(clr_en && !gclr_s);
		end
	end
	assign tdo = tdo_q;
	assign user_mode = state_q == ST_USER;
	assign chain_enable_out_n = !user_mode;
	assign config_bit_clock_out = config_bit_clock_q;
	assign config_bit_clock_oe = as_load;
	assign flash_serial_out = hdr_sr_q[31];
	assign flash_serial_oe = as_load;
	assign flash_select_n = !as_load;
	assign flash_select_oe = as_load;
	assign load_complete_out = 1'b0;
	assign load_complete_oe = state_q == ST_WAIT || state_q == ST_CLEAR ||
		(state_q == ST_LOAD && !load_end);
	assign load_status_n_out = 1'b0;
	assign load_status_n_oe = state_q == ST_CLEAR;
	assign init_done_out = 1'b0;
	assign init_done_oe = done_en && !user_mode;
	assign user_io_oe = (user_mode && !(oe_en && !goe_s)) ? user_oe_req : '0;

	// ***************************************************************
	// Checks
	// ***************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_RESTART_ABORT: assert property (!restart_s |=> state_q == ST_CLEAR)
		else $error("restart low did not reset sequencer");
	AST_RESTART_START: assert property ($rose(restart_s) && state_q == ST_CLEAR && restart_s
		|=> state_q == (ce_n_s ? ST_WAIT : ST_LOAD) || !restart_s)
		else $error("restart rise did not start loading");
	AST_CLEAR_FLOAT: assert property (state_q == ST_CLEAR |-> user_io_oe == '0)
		else $error("user pins driven during restart");
	AST_CHAIN_HOLD: assert property (state_q == ST_WAIT && ce_n_s && restart_s |=> state_q == ST_WAIT)
		else $error("loaded while chain enable high");
	AST_CHAIN_OUT: assert property (chain_enable_out_n == (state_q != ST_USER))
		else $error("chain output wrong");
	AST_AS_CLOCK: assert property (as_load && div_wrap ##1 as_load |-> config_bit_clock_q != $past(config_bit_clock_q))
		else $error("master bit clock did not toggle");
	AST_AS_SELECT: assert property (as_load |-> !flash_select_n && flash_select_oe && flash_serial_oe)
		else $error("memory not selected in master load");
	AST_BIT_COUNT: assert property (bit_take && state_q == ST_LOAD && restart_s
		|=> bit_cnt_q == $past(bit_cnt_q) + 32'h0000_0001)
		else $error("bit not counted");
	AST_DONE_RELEASE: assert property ($fell(load_complete_oe)
		|-> state_q == ST_LOAD && bit_cnt_q == len_q)
		else $error("load complete released early");
	AST_INIT_TO_USER: assert property (state_q == ST_INIT && !uclk_en && restart_s
		|-> ##[0:400] state_q != ST_INIT)
		else $error("initialization did not end");
	AST_OE_OVERRIDE: assert property (user_mode && oe_en && !goe_s |-> user_io_oe == '0)
		else $error("output override ignored");
	AST_CLEAR_OVERRIDE: assert property (user_mode && clr_en && !gclr_s |=> !user_reg_clear_n)
		else $error("global clear ignored");
	AST_DONE_PIN: assert property (done_en |-> init_done_oe == (state_q != ST_USER))
		else $error("user mode indication wrong");
	AST_STATUS_OD: assert property (!load_status_n_out && !load_complete_out)
		else $error("status pin driven high");
endmodule

//--- pkg/cfgpc_pkg.sv
// Constants, states and register map of the configuration pin controller
// How it works
// - Restart input low resets device and abandons loading or user operation
// - Restart input rising starts a new configuration sequence
// - While restart input is low every user pin floats
// - Passive serial: bit clock is an input driven by host, data sampled on it
// - Active serial: device is master and drives the bit clock out
// - Configuration data enters one bit at a time on the serial input
// - Device loads only while chain enable input is low, else stays idle
// - Chain enable output drives low once own initialization ends and user mode starts; feeds next device
// - Active serial: address and command shifted out to memory; else pin is user I/O
// - Active serial: memory select driven low; else pin is user I/O
// - When enabled, open-drain done pin signals user mode; else plain I/O
// - Optional user clock paces initialization; later usable as user I/O
// - Global clear enabled and low clears all user registers
// - Global output enable enabled and low floats all user pins
// - Two mode select inputs choose the configuration scheme
// - Load-complete and status pins are dedicated open-drain, never user I/O
// - Boundary-scan port with mode, data and clock in, data out
package cfgpc_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int AS_HALF_NS = 200;
	localparam int AS_HALF_CYC = (AS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CYCLES = 299;
	localparam int HDR_BITS = 32;
	localparam logic [31:0] AS_HEADER = 32'h0300_0000;
	localparam logic [1:0] MODE_AS = 2'h0;
	localparam logic [1:0] MODE_PS = 2'h1;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_LEN = 4'h4;
	localparam logic [3:0] OFS_STAT = 4'h8;
	localparam logic [3:0] OFS_COUNT = 4'hc;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] LEN_RESET = 32'h0000_0400;
	localparam int CTRL_CLR_EN = 0;
	localparam int CTRL_OE_EN = 1;
	localparam int CTRL_DONE_EN = 2;
	localparam int CTRL_UCLK_EN = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_CLEAR = 3'h0,
		ST_WAIT = 3'h1,
		ST_LOAD = 3'h2,
		ST_INIT = 3'h3,
		ST_USER = 3'h4
	} cfgpc_state_t;
endpackage

//--- design/cfgpc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cfgpc_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

//--- design/cfgpc_axil.sv
// AXI4-Lite register file of the configuration pin controller
`timescale 1ns/1ps
module cfgpc_axil import cfgpc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] stat_in,
	input wire logic [31:0] count_in,
	output logic [31:0] ctrl_q,
	output logic [31:0] len_q
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Write taken only when address and data are both offered
	wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	wire wr_ctrl = s_axi_awaddr == OFS_CTRL;
	wire wr_len = s_axi_awaddr == OFS_LEN;
	wire wr_hit = wr_ctrl || wr_len;
	wire rd_go = s_axi_arvalid && !s_axi_rvalid;
	wire rd_hit = s_axi_araddr == OFS_CTRL || s_axi_araddr == OFS_LEN ||
		s_axi_araddr == OFS_STAT || s_axi_araddr == OFS_COUNT;
	wire [31:0] rd_mux = s_axi_araddr == OFS_CTRL ? ctrl_q :
		s_axi_araddr == OFS_LEN ? len_q :
		s_axi_araddr == OFS_STAT ? stat_in :
		s_axi_araddr == OFS_COUNT ? count_in : 32'h0000_0000;

	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			len_q <= LEN_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			if (wr_go && wr_ctrl) begin
				ctrl_q <= merge(ctrl_q, s_axi_wdata, s_axi_wstrb);
			end
			if (wr_go && wr_len) begin
				len_q <= merge(len_q, s_axi_wdata, s_axi_wstrb);
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

//--- dv/cfgpc_host.sv
// Far-side model: passive-serial host and serial configuration memory
`timescale 1ns/1ps
module cfgpc_host import cfgpc_pkg::*; (
	input wire logic go,
	input wire logic [31:0] word,
	input wire logic sel_n,
	input wire logic mem_clk,
	output logic bit_clk,
	output logic data
);
	logic host_d = 1'b0;
	logic mem_d = 1'b0;
	int rises = 0;
	int idx = 0;
	initial bit_clk = 1'b0;
	// ****************
	// Host: bit clock only within the frame, 400 ns period
	// ****************
	always @(posedge go) begin
		// Keep link edges away from the sampling clock edge
		#10;
		for (int i = 31; i >= 0; i--) begin
			host_d = word[i];
			#200 bit_clk = 1'b1;
			#200 bit_clk = 1'b0;
		end
		host_d = ~host_d;
	end
	// ****************
	// Memory: answers after the header, changes data on falling clock
	// ****************
	always @(posedge mem_clk) begin
		if (!sel_n)
			rises++;
	end
	always @(negedge mem_clk) begin
		if (!sel_n && rises >= HDR_BITS && idx < 32) begin
			mem_d <= word[31-idx];
			idx++;
		end else
			mem_d <= ~mem_d;
	end
	// Deselected memory no longer holds its last bit
	assign data = sel_n ? host_d : mem_d;
endmodule

//--- dv/test_config_pin_control.sv
// Self-checking bench of the configuration pin controller
`timescale 1ns/1ps
module test_config_pin_control import cfgpc_pkg::*;;
	typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d; logic [1:0] r;} cfgpc_row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, cfg_word, q, got_word, hdr, word = 32'h0;
	logic config_restart_n = 1'b1, chain_enable_in_n = 1'b0, go = 1'b0;
	logic [1:0] config_mode_select = MODE_PS;
	logic global_clear_n = 1'b1, global_output_enable = 1'b1, init_user_clock = 1'b0;
	logic [7:0] user_oe_req = 8'h0, user_io_oe;
	logic chain_enable_out_n, config_bit_clock_in, config_bit_clock_out, config_bit_clock_oe;
	logic config_serial_in, flash_serial_out, flash_serial_oe, flash_select_n, flash_select_oe;
	logic load_complete_out, load_complete_oe, load_status_n_out, load_status_n_oe;
	logic init_done_oe, user_reg_clear_n, user_mode, cfg_word_valid;
	logic tms = 1'b0, tdi = 1'b0, tck = 1'b0, tdo;
	int err_count = 0;
	int samples_checked = 0;
	int hn = 0;
	cfgpc_row_t rows [9];
	always #25 aclk = ~aclk;
	always #300 init_user_clock = ~init_user_clock;
	// ****************
	// Device, far side and pulled-up open-drain pins
	// ****************
	cfgpc_top #(.IO_W(8), .INIT_CNT(4)) cfgpc_top_i (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.config_restart_n, .config_mode_select, .chain_enable_in_n, .chain_enable_out_n,
		.config_bit_clock_in, .config_bit_clock_out, .config_bit_clock_oe, .config_serial_in,
		.flash_serial_out, .flash_serial_oe, .flash_select_n, .flash_select_oe,
		.load_complete_in(~load_complete_oe | load_complete_out), .load_complete_out, .load_complete_oe,
		.load_status_n_in(~load_status_n_oe | load_status_n_out), .load_status_n_out, .load_status_n_oe,
		.init_done_out(), .init_done_oe, .init_user_clock, .global_clear_n, .global_output_enable,
		.tms, .tdi, .tck, .tdo, .user_oe_req, .user_io_oe, .user_reg_clear_n,
		.user_mode, .cfg_word, .cfg_word_valid);
	cfgpc_host cfgpc_host_i (.go, .word, .sel_n(flash_select_n | ~flash_select_oe),
		.mem_clk(config_bit_clock_out), .bit_clk(config_bit_clock_in), .data(config_serial_in));
	always @(posedge aclk) begin
		if (cfg_word_valid)
			got_word <= cfg_word;
	end
	always @(posedge config_bit_clock_out) begin
		if (flash_serial_oe && hn < 32) begin
			hdr <= {hdr[30:0], flash_serial_out};
			hn <= hn + 1;
		end
	end
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		if (wr) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		do begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_wready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
		r = wr ? s_axi_bresp : s_axi_rresp;
		q = s_axi_rdata;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
	task automatic restart(input logic [1:0] m);
		@(posedge aclk);
		config_restart_n <= 1'b0;
		config_mode_select <= m;
		repeat (4) @(posedge aclk);
		config_restart_n <= 1'b1;
	endtask
	task automatic jtag(input logic m, input logic b, input logic e);
		tms <= m;
		tdi <= b;
		repeat (3) @(posedge aclk);
		tck <= 1'b1;
		repeat (3) @(posedge aclk);
		tck <= 1'b0;
		repeat (4) @(posedge aclk);
		chk({31'h0, tdo}, {31'h0, e});
	endtask
	task automatic wait_user;
		int n;
		n = 0;
		while (user_mode !== 1'b1 && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		chk({31'h0, user_mode}, 32'h1);
	endtask
	task automatic final_report;
		if (err_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#1000000;
		err_count++;
		final_report;
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		rows = '{'{1'b0, OFS_CTRL, CTRL_RESET, RESP_OKAY}, '{1'b0, OFS_LEN, LEN_RESET, RESP_OKAY},
			'{1'b1, OFS_LEN, 32'h20, RESP_OKAY}, '{1'b0, OFS_LEN, 32'h20, RESP_OKAY},
			'{1'b1, OFS_CTRL, 32'h7, RESP_OKAY}, '{1'b0, OFS_CTRL, 32'h7, RESP_OKAY},
			'{1'b1, OFS_STAT, 32'hffffffff, RESP_SLVERR}, '{1'b1, OFS_COUNT, 32'h5, RESP_SLVERR},
			'{1'b0, OFS_COUNT, 32'h0, RESP_OKAY}};
		repeat (2) @(posedge aclk);
		chk({31'h0, chain_enable_out_n}, 32'h1);
		chk({24'h0, user_io_oe}, 32'h0);
		chk({30'h0, load_complete_oe, load_status_n_oe}, 32'h3);
		@(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			axi(rows[i].wr, rows[i].a, rows[i].d);
			chk({30'h0, r}, {30'h0, rows[i].r});
			if (!rows[i].wr)
				chk(q, rows[i].d);
		end
		jtag(1'b0, 1'b1, 1'b1);
		jtag(1'b1, 1'b0, 1'b1);
		jtag(1'b0, 1'b0, 1'b0);
		word <= 32'ha5c30f96;
		user_oe_req <= 8'h5a;
		restart(MODE_PS);
		repeat (6) @(posedge aclk);
		chk({30'h0, flash_select_oe, init_done_oe}, 32'h1);
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		wait_user;
		chk(got_word, 32'ha5c30f96);
		chk({30'h0, chain_enable_out_n, load_complete_oe}, 32'h0);
		chk({31'h0, init_done_oe}, 32'h0);
		chk({24'h0, user_io_oe}, 32'h5a);
		axi(1'b0, OFS_COUNT, 32'h0);
		chk(q, 32'h20);
		axi(1'b0, OFS_STAT, 32'h0);
		chk(q, 32'hd4);
		global_output_enable <= 1'b0;
		repeat (4) @(posedge aclk);
		chk({24'h0, user_io_oe}, 32'h0);
		global_output_enable <= 1'b1;
		global_clear_n <= 1'b0;
		repeat (4) @(posedge aclk);
		chk({31'h0, user_reg_clear_n}, 32'h0);
		global_clear_n <= 1'b1;
		repeat (4) @(posedge aclk);
		chk({16'h0, user_io_oe, 7'h0, user_reg_clear_n}, 32'h5a01);
		config_restart_n <= 1'b0;
		repeat (4) @(posedge aclk);
		chk({24'h0, user_io_oe}, 32'h0);
		chk({30'h0, user_mode, chain_enable_out_n}, 32'h1);
		chain_enable_in_n <= 1'b1;
		restart(MODE_PS);
		repeat (8) @(posedge aclk);
		axi(1'b0, OFS_STAT, 32'h0);
		chk(q & 32'h7, 32'h1);
		chain_enable_in_n <= 1'b0;
		axi(1'b1, OFS_CTRL, 32'hf);
		word <= 32'h3c965aa5;
		restart(MODE_AS);
		repeat (8) @(posedge aclk);
		chk({29'h0, flash_select_n, flash_select_oe, config_bit_clock_oe}, 32'h3);
		wait_user;
		chk(hdr, AS_HEADER);
		chk(got_word, 32'h3c965aa5);
		chk({31'h0, flash_select_oe}, 32'h0);
		final_report;
	end
endmodule
